// ==== inc/gsp_params.svh ====
// Purpose: constants of the gated serial-in, parallel-out shifter
// Assumes: one 100 MHz system clock, pins sampled through two flip-flops
// Notes: the operation overview below is kept brief on purpose
//
// Overview of operation
// - eight chained stages, each on parallel output
// - first stage input is AND of inputs
// - stages change only on clock rising edge or clear low
// - rising edge loads gated bit, shifts chain
// - eighth stage old value dropped, no serial out
// - clear low forces all stages zero immediately
// - no edge, no clear: outputs hold level
// - serial inputs sampled only at rising edge
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH

`define GSP_STAGES 8
`define GSP_STAGE_RST 8'h00
`define GSP_BUF_DEPTH 2
`define GSP_FIRST 0
`define GSP_LAST 7

`endif

// ==== inc/gsp_pkg.sv ====
// Purpose: shared types of the shifter
// Assumes: gsp_params.svh gives the stage count
// Notes: clock and serial pins travel as one packed struct; clear_n has a port of its own
`include "gsp_params.svh"

package gsp_pkg;
    // pin group driven by the external controller
    typedef struct packed {
        logic shift_clk;
        logic ser_a;
        logic ser_b;
    } gsp_pins_type;

    // one parallel snapshot of the chain
    typedef logic [`GSP_STAGES-1:0] gsp_word_type;
endpackage

// ==== rtl/gsp_buffer.sv ====
// Purpose: small valid/ready buffer for parallel snapshots
// Assumes: single clock, asynchronous active-low reset
// Notes: depth and width are parameters that shape the storage
`timescale 1ns/10ps

module gsp_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest full and empty from the entry count
    assign in_ready = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];

    // storage has no reset; only valid entries are ever read
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    // pointers wrap at depth so a non-power-of-two depth also works
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ==== rtl/gsp_shifter.sv ====
// Purpose: eight-stage shifter with AND-gated serial entry and direct clear
// Assumes: pins are asynchronous to ref_clk and slower than ref_clk / 4
// Notes: each shift also offers a snapshot word through a two-entry buffer
`timescale 1ns/10ps
`include "gsp_params.svh"

module gsp_shifter #(
    parameter int STAGES = `GSP_STAGES,
    parameter int BUF_DEPTH = `GSP_BUF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire gsp_pkg::gsp_pins_type pins,
    input wire logic clear_n,
    output gsp_pkg::gsp_word_type stage_out,
    output logic stage_one_out,
    output logic stage_eight_out,
    output logic snap_valid,
    input wire logic snap_ready,
    output gsp_pkg::gsp_word_type snap_data,
    output logic snap_space
);
    import gsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    gsp_pins_type pins_m_q;
    gsp_pins_type pins_s_q;
    gsp_pins_type pins_d_q;
    logic clr_m_q;
    logic clr_s_q;

    // two flops per pin; clock, data and clear see the same latency
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pins_m_q <= '0;
            pins_s_q <= '0;
            pins_d_q <= '0;
            clr_m_q <= 1'b0;
            clr_s_q <= 1'b0;
        end
        else
        begin
            pins_m_q <= pins;
            pins_s_q <= pins_m_q;
            pins_d_q <= pins_s_q;
            clr_m_q <= clear_n;
            clr_s_q <= clr_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge detect and serial gate

    wire clk_rise = pins_s_q.shift_clk && !pins_d_q.shift_clk;
    // a falling edge or a steady level gives no pulse at all
    wire shift_pulse = clk_rise && clr_s_q;
    // data taken from the same sync stage as the edge, so only edge time counts
    wire gated_bit = pins_s_q.ser_a & pins_s_q.ser_b;

    ////////////////////////////////////////////////////////////////////////
    // stage chain

    gsp_word_type stage_q;
    gsp_word_type stage_d;
    // clear acts on the stage flops directly, not through the synchroniser
    wire stage_clr_n = rstn & clear_n;

    // one entry per stage: first takes the gated bit, the rest their neighbour
    generate
        for (genvar i = 0; i < STAGES; i++)
        begin : g_stage
            if (i == `GSP_FIRST)
            begin : g_head
                assign stage_d[i] = shift_pulse ? gated_bit : stage_q[i];
            end
            else
            begin : g_body
                assign stage_d[i] = shift_pulse ? stage_q[i-1] : stage_q[i];
            end
        end
    endgenerate

    // last stage's old value simply falls off; there is no serial output
    always_ff @(posedge ref_clk or negedge stage_clr_n)
    begin
        if (!stage_clr_n)
            stage_q <= `GSP_STAGE_RST;
        else
            stage_q <= stage_d;
    end

    // parallel outputs straight from the stage flops
    assign stage_out = stage_q;
    assign stage_one_out = stage_q[`GSP_FIRST];
    assign stage_eight_out = stage_q[`GSP_LAST];

    ////////////////////////////////////////////////////////////////////////
    // snapshot stream

    logic push_q;

    // offer the new chain value in the cycle the shift lands, one cycle after the shift pulse
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            push_q <= 1'b0;
        else
            push_q <= shift_pulse;
    end

    // the pins cannot be stalled, so space is reported for the controller
    gsp_buffer #(
        .WIDTH(STAGES),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(push_q),
        .in_ready(snap_space),
        .in_data(stage_q),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // ports mirror the chain bit for bit, ends included
    parallel_map_a: assert property (
        stage_out == stage_q && stage_one_out == stage_q[0]
        && stage_eight_out == stage_q[STAGES-1])
        else $error("parallel outputs differ from stages");

    // first stage gets the AND of both serial inputs
    serial_gate_a: assert property (
        shift_pulse && clear_n && $past(clear_n) |=>
        stage_q[0] == ($past(pins_s_q.ser_a) && $past(pins_s_q.ser_b)))
        else $error("first stage not AND of serial inputs");

    // a pin rising edge leads to one shift two to four cycles later;
    // clear must be high when the rise is sampled, as the clear sync lags alike
    edge_shift_a: assert property (
        $rose(pins.shift_clk) && clear_n |-> ##[2:4] shift_pulse)
        else $error("rising clock edge did not shift");

    // a falling pin edge never shifts
    fall_quiet_a: assert property (
        $fell(pins_s_q.shift_clk) |-> !shift_pulse)
        else $error("falling edge caused a shift");

    // every other stage takes its neighbour's old value
    chain_move_a: assert property (
        shift_pulse && clear_n |=> clear_n |-> stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]))
        else $error("chain did not move one place");

    // eighth stage ends up holding the seventh's old value
    last_drop_a: assert property (
        shift_pulse && clear_n |=> clear_n |-> stage_eight_out == $past(stage_q[STAGES-2]))
        else $error("eighth stage not replaced by seventh");

    // clear low means all zero, whatever clock and data do
    clear_zero_a: assert property (
        !clear_n |-> stage_q == `GSP_STAGE_RST && stage_out == `GSP_STAGE_RST)
        else $error("stages not zero under clear");

    // without an edge the outputs hold across several cycles
    hold_level_a: assert property (
        (!shift_pulse && clear_n) [*3] |=> clear_n |-> stage_out == $past(stage_out, 3))
        else $error("outputs drifted without an edge");

    // data toggling between edges leaves the chain alone
    data_quiet_a: assert property (
        $changed(pins_s_q.ser_a) && !shift_pulse && clear_n |=> clear_n |-> $stable(stage_q))
        else $error("serial data changed the chain between edges");

    // a synchronised rise gives exactly one shift pulse
    single_pulse_a: assert property (
        shift_pulse |=> !shift_pulse)
        else $error("one clock edge shifted twice");

    // two cycles of clear at the pin block any shift right after its release
    clear_block_a: assert property (
        !clear_n [*2] ##1 clear_n |-> !shift_pulse)
        else $error("shift taken just after clear");

    // a word offered to an empty buffer shows at its head next cycle
    snap_word_a: assert property (
        push_q && !snap_valid |=> snap_valid && snap_data == $past(stage_q))
        else $error("snapshot word differs from stages");

    // a stalled head word stands until the receiver takes it
    snap_keep_a: assert property (
        snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
        else $error("stalled snapshot word changed");

    // cycles since the last shift, saturating; a long idle gap is checked
    // one cycle at a time instead of through a long repetition
    logic [3:0] idle_cnt_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            idle_cnt_q <= '0;
        else if (shift_pulse)
            idle_cnt_q <= '0;
        else if (idle_cnt_q != '1)
            idle_cnt_q <= idle_cnt_q + 1'b1;
    end

    // with no shift last cycle and clear high the stages stay put
    idle_hold_a: assert property (
        idle_cnt_q != '0 && clear_n |-> $stable(stage_q))
        else $error("stages moved during an idle gap");

    // main scenarios: both gate outcomes, a mid-run clear, a full buffer, a drain
    shift_one_c: cover property (shift_pulse && gated_bit);
    shift_zero_c: cover property (shift_pulse && !gated_bit);
    clear_mid_c: cover property (stage_q != '0 ##1 !clear_n);
    buf_full_c: cover property (!snap_space && snap_valid && !snap_ready);
    snap_drain_c: cover property (snap_valid && snap_ready ##1 !snap_valid);
endmodule

// ==== dv/gsp_ctrl_model.sv ====
// Purpose: controller model that drives the shifter pins
// Assumes: pins change only at falling edges of ref_clk
// Notes: shift clock stands low between bits; data flips once its hold ends
`timescale 1ns/10ps

module gsp_ctrl_model
(
    input wire logic ref_clk,
    output gsp_pkg::gsp_pins_type pins
);
    import gsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // idle: clock low, serial lines low
    initial
    begin
        pins = '0;
    end

    // one bit per rise; 3-cycle phases cover the 2-flop sampling delay
    task automatic send_bit(input logic a, input logic b);
    begin
        @(negedge ref_clk);
        pins.ser_a = a;
        pins.ser_b = b;
        repeat (3) @(negedge ref_clk);
        pins.shift_clk = 1'b1;
        repeat (3) @(negedge ref_clk);
        // hold has run out, so flip data: a late sample would show
        pins.ser_a = ~a;
        pins.ser_b = ~b;
        pins.shift_clk = 1'b0;
        repeat (3) @(negedge ref_clk);
    end
    endtask
endmodule

// ==== dv/gsp_shifter_tb.sv ====
// Purpose: self-checking bench for the gated shifter
// Assumes: 100 MHz ref_clk, bench inputs change at falling edges
// Notes: snapshots are only tracked while the receiver stalls
`timescale 1ns/10ps

module gsp_shifter_tb;
    import gsp_pkg::*;

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clear_n = 1'b1;
    logic snap_ready = 1'b1;
    gsp_pins_type pins;
    gsp_word_type stage_out;
    gsp_word_type snap_data;
    logic stage_one_out;
    logic stage_eight_out;
    logic snap_valid;
    logic snap_space;
    gsp_word_type exp_q = 8'h00;
    gsp_word_type snaps[$];
    int error_cnt = 0;
    int n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    gsp_ctrl_model u_gsp_ctrl_model (.ref_clk(ref_clk), .pins(pins));

    gsp_shifter u_gsp_shifter (.ref_clk(ref_clk), .rstn(rstn), .pins(pins),
        .clear_n(clear_n), .stage_out(stage_out), .stage_one_out(stage_one_out),
        .stage_eight_out(stage_eight_out), .snap_valid(snap_valid),
        .snap_ready(snap_ready), .snap_data(snap_data), .snap_space(snap_space));

    ////////////////////////////////////////////////////////////////////////
    // shared compare and closing
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic close_out;
    begin
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // one shift, stage check, and the snapshot it should leave while stalled
    task automatic shift(input logic a, input logic b);
    begin
        u_gsp_ctrl_model.send_bit(a, b);
        exp_q = {exp_q[6:0], a & b};
        chk("stage_out", exp_q, stage_out);
        if (snap_ready === 1'b0 && snaps.size() < 2)
            snaps.push_back(exp_q);
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every gate combination enters stage one
    task automatic t_gate;
    begin
        for (int i = 0; i < 4; i++)
        begin
            shift(i[1], i[0]);
            chk("stage_one_out", {7'h00, i[1] & i[0]}, {7'h00, stage_one_out});
        end
    end
    endtask

    // fill with ones, then a pattern pushes every old bit out
    task automatic t_pattern;
        logic [7:0] pat;
    begin
        pat = 8'h35;
        repeat (8) shift(1'b1, 1'b1);
        chk("stage_out", 8'hFF, stage_out);
        for (int i = 7; i >= 0; i--)
            shift(pat[i], 1'b1);
        chk("stage_out", 8'h35, stage_out);
        chk("stage_eight_out", 8'h00, {7'h00, stage_eight_out});
    end
    endtask

    // direct clear without a clock edge, then hold while idle
    task automatic t_clear;
    begin
        @(negedge ref_clk);
        clear_n = 1'b0;
        #1;
        chk("stage_out", 8'h00, stage_out);
        repeat (3) @(negedge ref_clk);
        clear_n = 1'b1;
        exp_q = 8'h00;
        repeat (3) @(negedge ref_clk);
        shift(1'b1, 1'b1);
        repeat (20) @(negedge ref_clk);
        chk("stage_out", 8'h01, stage_out);
    end
    endtask

    // stall the receiver until the buffer refuses, then drain in order
    task automatic t_buffer;
    begin
        @(negedge ref_clk);
        snap_ready = 1'b0;
        snaps.delete();
        shift(1'b1, 1'b0);
        shift(1'b1, 1'b1);
        shift(1'b1, 1'b1);
        chk("snap_space", 8'h00, {7'h00, snap_space});
        chk("stage_out", exp_q, stage_out);
        snap_ready = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            chk("snap_valid", 8'h01, {7'h00, snap_valid});
            chk("snap_data", snaps[k], snap_data);
            @(negedge ref_clk);
        end
        chk("snap_valid", 8'h00, {7'h00, snap_valid});
        chk("snap_space", 8'h01, {7'h00, snap_space});
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_gate();
        t_pattern();
        t_clear();
        t_buffer();
        close_out();
    end

    // watchdog: the run needs about 3 us
    initial
    begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule
